/* File: hw/image_mem.sv */
// source image memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module image_mem #(
    parameter int AW = 17,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    // read port
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    // no reset: memory contents are loaded by the user before a job
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // image_mem
`default_nettype wire

/* File: hw/prom_programmer.sv */
// page-mode prom programmer driving the device pins
// Operation
// - enter programming mode: vpp raised, reset low
// - latch four bytes: ce high, oe low
// - page pulse 0.1 ms, ce oe high
// - no byte write pulse: the strobe falls only with ce high, for a page
// - pulse-verify each page at most ten times in all, then flag defective
// - read: reset low, address, sample data
// - latch consecutive addresses, pulse, verify page
// - final read verify, flag defective
`include "prom_prog_params.svh"
`timescale 1ns/100ps
`default_nettype none
module prom_programmer #(
    parameter int PULSE_CYCLES = `PULSE_CYCLES,
    parameter int SETUP_CYCLES = `SETUP_CYCLES,
    parameter int MAX_RETRIES = `MAX_RETRIES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // image load
    input wire logic loadEn,
    input wire logic [`ADDR_WIDTH-1:0] loadAddr,
    input wire logic [`DATA_WIDTH-1:0] loadData,
    // job request
    input wire logic start,
    input wire logic [`ADDR_WIDTH-1:0] firstAddr,
    input wire logic [`ADDR_WIDTH-1:0] lastAddr,
    output prom_prog_pkg::status_t status,
    // device pins
    output prom_prog_pkg::pin_ctrl_t pins,
    output logic [`ADDR_WIDTH-1:0] prom_address_bus,
    output logic [`DATA_WIDTH-1:0] dataOut,
    output logic dataOe_n,
    input wire logic [`DATA_WIDTH-1:0] prom_data_bus
);
    typedef enum logic [3:0] {
        IDLE = 4'h0, LATCH = 4'h1, PULSE = 4'h2, VERIFY = 4'h3,
        RECOVER = 4'h4, READV = 4'h5, FINISH = 4'h6
    } state_t;

    // ****************************************
    // image memory
    // ****************************************
    logic [`ADDR_WIDTH-1:0] rdAddr;
    logic [`DATA_WIDTH-1:0] imgData;
    image_mem #(.AW(`ADDR_WIDTH), .DW(`DATA_WIDTH)) u_img (
        .clk(clk),
        .wrEn(loadEn),
        .wrAddr(loadAddr),
        .wrData(loadData),
        .rdAddr(rdAddr),
        .rdData(imgData)
    );

    // ****************************************
    // sequencer
    // ****************************************
    state_t state, next_state;
    logic [`ADDR_WIDTH-1:0] pageBase, next_pageBase, last, next_last;
    logic [1:0] idx, next_idx;
    logic [3:0] retries, next_retries;
    logic [31:0] timer, next_timer;
    logic pageFail, next_pageFail;
    prom_prog_pkg::pin_ctrl_t next_pins;
    prom_prog_pkg::status_t next_status;
    logic [`ADDR_WIDTH-1:0] next_addrBus;
    logic [`DATA_WIDTH-1:0] next_dataOut;
    logic next_dataOe_n;

    function automatic logic [`ADDR_WIDTH-1:0] addrOf(input logic [`ADDR_WIDTH-1:0] base, input logic [1:0] i);
        addrOf = base + {{(`ADDR_WIDTH-2){1'b0}}, i};
    endfunction

    // the memory read address leads the pins so data is ready when the phase starts
    assign rdAddr = addrOf(pageBase, idx);

    // next-state logic; timer stalls each phase so pin levels settle before sampling
    always_comb begin
        next_state = state;
        next_pageBase = pageBase;
        next_last = last;
        next_idx = idx;
        next_retries = retries;
        next_timer = timer;
        next_pageFail = pageFail;
        next_pins = pins;
        next_status = status;
        next_addrBus = prom_address_bus;
        next_dataOut = dataOut;
        next_dataOe_n = dataOe_n;
        unique case (state)
            IDLE: begin
                // standby: ce high, strobe high, reset held low
                next_pins = '{chipEnable_n: 1'b1, outputEnable_n: 1'b1, program_strobe_n: 1'b1,
                              highVoltage: 1'b0, holdReset_n: 1'b0};
                next_dataOe_n = 1'b1;
                if (start) begin
                    next_pageBase = {firstAddr[`ADDR_WIDTH-1:2], 2'b00};
                    next_last = lastAddr;
                    next_idx = 2'b00;
                    next_retries = 4'h0;
                    next_timer = 32'h0;
                    next_status = '{busy: 1'b1, done: 1'b0, defective: 1'b0};
                    next_pins.highVoltage = 1'b1;
                    next_state = LATCH;
                end
            end
            LATCH: begin
                // drive address and data, then oe low with ce high
                next_pins.chipEnable_n = 1'b1;
                next_pins.program_strobe_n = 1'b1;
                next_addrBus = addrOf(pageBase, idx);
                next_dataOut = imgData;
                next_dataOe_n = 1'b0;
                next_pins.outputEnable_n = (timer < SETUP_CYCLES) ? 1'b1 : 1'b0;
                next_timer = timer + 32'h1;
                if (timer == 32'(2 * SETUP_CYCLES)) begin
                    next_pins.outputEnable_n = 1'b1;
                    next_timer = 32'h0;
                    next_idx = idx + 2'b01;
                    if (idx == 2'b11) begin
                        next_state = PULSE;
                    end
                end
            end
            PULSE: begin
                // ce and oe high, data floated by us, strobe low for the pulse time
                next_dataOe_n = 1'b1;
                next_pins.outputEnable_n = 1'b1;
                next_pins.chipEnable_n = 1'b1;
                next_pins.program_strobe_n = (timer < 32'(PULSE_CYCLES)) ? 1'b0 : 1'b1;
                next_timer = timer + 32'h1;
                if (timer == 32'(PULSE_CYCLES + SETUP_CYCLES)) begin
                    next_timer = 32'h0;
                    next_idx = 2'b00;
                    next_pageFail = 1'b0;
                    next_state = VERIFY;
                end
            end
            VERIFY: begin
                // ce low, oe low: device drives the stored byte
                next_pins.chipEnable_n = 1'b0;
                next_pins.outputEnable_n = 1'b0;
                next_addrBus = addrOf(pageBase, idx);
                next_timer = timer + 32'h1;
                if (timer == 32'(2 * SETUP_CYCLES)) begin
                    next_timer = 32'h0;
                    next_pageFail = pageFail | (prom_data_bus != imgData);
                    next_idx = idx + 2'b01;
                    if (idx == 2'b11) begin
                        next_state = RECOVER;
                    end
                end
            end
            RECOVER: begin
                next_pins.chipEnable_n = 1'b1;
                next_pins.outputEnable_n = 1'b1;
                next_idx = 2'b00;
                if (pageFail) begin
                    next_retries = retries + 4'h1;
                    if (retries + 4'h1 >= 4'(MAX_RETRIES)) begin
                        // drop the high supply with done, so a rejected part is never left at program levels
                        next_status = '{busy: 1'b0, done: 1'b1, defective: 1'b1};
                        next_pins.highVoltage = 1'b0;
                        next_state = IDLE;
                    end else begin
                        next_state = LATCH;
                    end
                end else if (pageBase + 17'h3 >= last) begin
                    next_pageBase = {firstAddr[`ADDR_WIDTH-1:2], 2'b00};
                    next_pins.highVoltage = 1'b0;
                    next_state = READV;
                end else begin
                    next_pageBase = pageBase + 17'h4;
                    next_retries = 4'h0;
                    next_state = LATCH;
                end
            end
            READV: begin
                // normal-supply read of every byte
                next_pins.chipEnable_n = 1'b0;
                next_pins.outputEnable_n = 1'b0;
                next_addrBus = addrOf(pageBase, idx);
                next_timer = timer + 32'h1;
                if (timer == 32'(2 * SETUP_CYCLES)) begin
                    next_timer = 32'h0;
                    next_pageFail = pageFail | (prom_data_bus != imgData);
                    next_idx = idx + 2'b01;
                    if (idx == 2'b11) begin
                        next_pageBase = pageBase + 17'h4;
                        if (pageBase + 17'h3 >= last) begin
                            next_state = FINISH;
                        end
                    end
                end
            end
            FINISH: begin
                next_pins.outputEnable_n = 1'b1;
                next_pins.chipEnable_n = 1'b1;
                next_status = '{busy: 1'b0, done: 1'b1, defective: pageFail};
                next_state = IDLE;
            end
            default: next_state = IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= IDLE;
            pageBase <= '0;
            last <= '0;
            idx <= 2'b00;
            retries <= 4'h0;
            timer <= 32'h0;
            pageFail <= 1'b0;
            pins <= '{chipEnable_n: 1'b1, outputEnable_n: 1'b1, program_strobe_n: 1'b1,
                      highVoltage: 1'b0, holdReset_n: 1'b0};
            status <= '0;
            prom_address_bus <= '0;
            dataOut <= 8'h00;
            dataOe_n <= 1'b1;
        end else begin
            state <= next_state;
            pageBase <= next_pageBase;
            last <= next_last;
            idx <= next_idx;
            retries <= next_retries;
            timer <= next_timer;
            pageFail <= next_pageFail;
            pins <= next_pins;
            status <= next_status;
            prom_address_bus <= next_addrBus;
            dataOut <= next_dataOut;
            dataOe_n <= next_dataOe_n;
        end
    end
endmodule // prom_programmer
`default_nettype wire

/* File: include/prom_prog_params.svh */
// timing, geometry and limit constants for the prom programmer
`ifndef PROM_PROG_PARAMS_SVH
`define PROM_PROG_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define PULSE_TIME_US 100
`define PULSE_CYCLES ((`PULSE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SETUP_CYCLES 4
`define MAX_RETRIES 10
`define PAGE_BYTES 4
`define ADDR_WIDTH 17
`define DATA_WIDTH 8
`define IMAGE_DEPTH 131072
`endif

/* File: include/prom_prog_pkg.sv */
// types shared by the prom programmer files
package prom_prog_pkg;
    typedef struct packed {
        logic chipEnable_n;
        logic outputEnable_n;
        logic program_strobe_n;
        logic highVoltage;
        logic holdReset_n;
    } pin_ctrl_t;
    typedef struct packed {
        logic busy;
        logic done;
        logic defective;
    } status_t;
endpackage

/* File: tb/prom_device_model.sv */
// behavioural model of the one-time prom behind the programming pins
`timescale 1ns/100ps
`default_nettype none
module prom_device_model (
    // sampling clock and pins
    input wire logic clk,
    input wire prom_prog_pkg::pin_ctrl_t pins,
    input wire logic [16:0] addr,
    input wire logic [7:0] busIn,
    // page writes to ignore, counted from time zero
    input wire logic [7:0] failWrites,
    // data side
    output logic [7:0] devData,
    output logic devDrive
);
    // ****************
    // storage and page latch
    // ****************
    logic [7:0] mem [0:131071];
    logic [7:0] pageLatch [0:3];
    logic [16:0] pageBase;
    int skipped = 0;
    int pulses = 0;
    initial for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
    // latch follows the bus while latch mode holds
    always @(posedge clk) begin
        if (pins.chipEnable_n && !pins.outputEnable_n && pins.program_strobe_n) begin
            pageLatch[addr[1:0]] <= busIn;
            pageBase <= {addr[16:2], 2'h0};
        end
    end
    // only a falling strobe writes; a held-high strobe writes nothing
    always @(negedge pins.program_strobe_n) begin
        pulses++;
        if (skipped < failWrites) skipped++;
        else if (pins.chipEnable_n && pins.outputEnable_n) begin
            for (int i = 0; i < 4; i++) mem[pageBase + 17'(i)] &= pageLatch[i];
        end else if (pins.outputEnable_n) mem[addr] &= busIn;
    end
    // drive only in verify or read; otherwise the bus floats
    assign devDrive = !pins.chipEnable_n && !pins.outputEnable_n && pins.program_strobe_n;
    assign devData = mem[addr];
endmodule // prom_device_model
`default_nettype wire

/* File: tb/prom_programmer_props.sv */
// concurrent checks on the prom programmer device pins and job status
`timescale 1ns/100ps
`default_nettype none
module prom_programmer_props #(
    parameter int PULSE_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // job side
    input wire logic start,
    input wire prom_prog_pkg::status_t status,
    // device side
    input wire prom_prog_pkg::pin_ctrl_t pins,
    input wire logic [16:0] prom_address_bus,
    input wire logic [7:0] dataOut,
    input wire logic dataOe_n
);
    // ****************
    // pulse length counter
    // ****************
    int lowCnt;
    int next_lowCnt;
    // cleared while the strobe is high, so a rising strobe sees the whole pulse
    always_comb next_lowCnt = pins.program_strobe_n ? 0 : lowCnt + 1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) lowCnt <= 0;
        else lowCnt <= next_lowCnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_reset_pin_low: assert property (pins.holdReset_n == 1'b0)
        else $error("reset pin released");
    chk_drive_latch_only: assert property (!dataOe_n |-> pins.chipEnable_n && pins.program_strobe_n)
        else $error("data driven outside latch");
    chk_pulse_levels: assert property (!pins.program_strobe_n |-> pins.chipEnable_n && pins.outputEnable_n && pins.highVoltage && dataOe_n)
        else $error("pulse with wrong levels");
    chk_pulse_width: assert property ($rose(pins.program_strobe_n) |-> lowCnt == PULSE_CYCLES)
        else $error("pulse width wrong");
    chk_pulse_bound: assert property (!pins.program_strobe_n |-> lowCnt < PULSE_CYCLES)
        else $error("pulse too long");
    chk_pulse_stable: assert property (!pins.program_strobe_n && !$past(pins.program_strobe_n) |-> $stable(prom_address_bus) && $stable(pins))
        else $error("lines moved in pulse");
    chk_latch_held: assert property (!dataOe_n && pins.chipEnable_n && !pins.outputEnable_n && !$past(pins.outputEnable_n) |-> $stable(dataOut) && $stable(prom_address_bus))
        else $error("latch data moved");
    chk_start_taken: assert property (start && !status.busy |=> status.busy && !status.done)
        else $error("start not taken");
    chk_done_levels: assert property (status.done |-> !status.busy && !pins.highVoltage)
        else $error("done at wrong levels");
    chk_defect_done: assert property (status.defective |-> status.done)
        else $error("defective without done");
endmodule // prom_programmer_props
`default_nettype wire

/* File: tb/test_prom_programmer.sv */
// self-checking bench for the prom programmer against the prom model
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin errorCnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module test_prom_programmer;
    // ****************
    // stimulus and wiring
    // ****************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic loadEn = 1'b0;
    logic start = 1'b0;
    logic [16:0] loadAddr = 17'h0, firstAddr = 17'h0, lastAddr = 17'h0, promAddr;
    logic [7:0] loadData = 8'h0, failWrites = 8'h0, lastBus = 8'h0, devData, dataOut;
    logic dataOe_n, devDrive;
    wire logic [7:0] busWire;
    prom_prog_pkg::status_t status;
    prom_prog_pkg::pin_ctrl_t pins;
    int errorCnt = 0;
    int numChecks = 0;
    int p0;
    always #5 clk = ~clk;
    // a floating bus shows the inverse of its last level, never a kind value
    assign busWire = !dataOe_n ? dataOut : devDrive ? devData : ~lastBus;
    always @(posedge clk) lastBus <= busWire;
    prom_programmer #(.PULSE_CYCLES(20)) i_dut (.clk(clk), .nrst(nrst), .loadEn(loadEn), .loadAddr(loadAddr),
        .loadData(loadData), .start(start), .firstAddr(firstAddr), .lastAddr(lastAddr), .status(status),
        .pins(pins), .prom_address_bus(promAddr), .dataOut(dataOut), .dataOe_n(dataOe_n), .prom_data_bus(busWire));
    prom_device_model i_prom (.clk(clk), .pins(pins), .addr(promAddr), .busIn(busWire), .failWrites(failWrites),
        .devData(devData), .devDrive(devDrive));
    function automatic logic [7:0] pat(input logic [16:0] a);
        return 8'h3C ^ a[7:0];
    endfunction
    task automatic finalReport();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // load a run of image bytes while idle
    task automatic loadRun(input logic [16:0] a);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) #1;
            loadEn = 1'b1;
            loadAddr = a + 17'(i);
            loadData = pat(loadAddr);
        end
        @(posedge clk) #1;
        loadEn = 1'b0;
    endtask
    // one job: start for a cycle, then wait for done under a bound
    task automatic runJob(input logic [16:0] f, input logic [16:0] l);
        p0 = i_prom.pulses;
        @(posedge clk) #1;
        firstAddr = f;
        lastAddr = l;
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
        for (int i = 0; i < 4000 && status.done !== 1'b1; i++) begin
            @(posedge clk) #1;
        end
        `CHECK("done", 1'b1, status.done)
    endtask
    task automatic tReset();
        `CHECK("pins", 5'h1C, pins)
        `CHECK("oe", 1'b1, dataOe_n)
        `CHECK("status", 3'h0, status)
    endtask
    // range rounds out to whole pages; nothing past the last page is touched
    task automatic tPages();
        loadRun(17'h0);
        runJob(17'h1, 17'h6);
        `CHECK("defective", 1'b0, status.defective)
        `CHECK("pulses", 2, i_prom.pulses - p0)
        for (int i = 0; i < 8; i++) `CHECK("mem", pat(17'(i)), i_prom.mem[i])
        `CHECK("mem8", 8'hFF, i_prom.mem[8])
    endtask
    // two failed writes, then success on the third pulse
    task automatic tRetry();
        loadRun(17'h10);
        failWrites = 8'(i_prom.skipped) + 8'h02;
        runJob(17'h10, 17'h13);
        `CHECK("defective", 1'b0, status.defective)
        `CHECK("pulses", 3, i_prom.pulses - p0)
        `CHECK("mem", pat(17'h13), i_prom.mem[19])
    endtask
    // a page that never programs; a start while busy is ignored
    task automatic tDefect();
        loadRun(17'h40);
        failWrites = 8'hFF;
        fork
            begin
                repeat (80) @(posedge clk);
                #1 start = 1'b1;
                @(posedge clk) #1;
                start = 1'b0;
            end
        join_none
        runJob(17'h40, 17'h43);
        `CHECK("defective", 1'b1, status.defective)
        `CHECK("retries", 10, i_prom.pulses - p0)
        `CHECK("refused", 8'hFF, i_prom.mem[64])
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        tReset();
        tPages();
        tRetry();
        tDefect();
        finalReport();
    end
    // watchdog well past the longest job sequence
    initial begin
        #400000;
        errorCnt++;
        finalReport();
    end
endmodule // test_prom_programmer
bind prom_programmer prom_programmer_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (.clk(clk), .nrst(nrst),
    .start(start), .status(status), .pins(pins), .prom_address_bus(prom_address_bus), .dataOut(dataOut),
    .dataOe_n(dataOe_n));
`default_nettype wire
